/* hdl/sfcc_config_ctrl.sv */
`timescale 1ns/100ps

// =====================================================
// small synchronous fifo
module sfcc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic clk, // clock
    input wire logic arst_n, // async reset, active low
    input wire logic in_valid, // write offered
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // word written
    output logic out_valid, // word available
    input wire logic out_ready, // reader takes word
    output logic [WIDTH-1:0] out_data // oldest word
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_ff [DEPTH]; // storage
    logic [AW-1:0] wr_ff; // write index
    logic [AW-1:0] rd_ff; // read index
    logic [AW:0] cnt_ff; // fill level
    logic push; // write this cycle
    logic pop; // read this cycle

    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    // pointers wrap at the depth
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + AW'(1);
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + AW'(1);
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// =====================================================
// serial flash configuration control
module sfcc_config_ctrl #(
    parameter int unsigned CLEAR_CYCLES = sfcc_pkg::CLEAR_CYC, // clearing time
    parameter int unsigned CFG_BYTES = 64, // stream bytes before crc
    parameter int unsigned FIFO_DEPTH = 4 // words of buffering
) (
    input wire logic ref_clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic osc_clk, // internal oscillator clock
    input wire logic reconfig_request_n, // reprogram pin, active low
    input wire logic [2:0] mode_pins, // boot mode straps
    input wire logic [1:0] clock_rate_option, // serial clock rate
    input wire logic pullup_disable, // pull-up disable pin
    output logic pullup_en, // pull-ups on during config
    input wire logic init_in, // init line level
    output logic init_out, // init line drive value
    output logic init_oe, // init line pulled low
    output logic done_out, // done line drive value
    output logic done_oe, // done line pulled low
    output logic flash_select_n, // flash select pin
    output logic flash_select_oe, // select driven
    output logic cfg_serial_clock, // serial clock pin
    output logic sclk_oe, // serial clock driven
    output logic mosi, // data to flash
    output logic mosi_oe, // data pin driven
    input wire logic flash_din, // data from flash
    output logic chain_dout, // chain serial output
    output logic chain_dout_oe, // chain output driven
    input wire sfcc_pkg::sfcc_pins_t app_pins, // application pin values
    output logic [7:0] cfg_data, // configuration byte
    output logic cfg_valid, // byte available
    input wire logic cfg_ready, // byte taken
    output sfcc_pkg::sfcc_status_t status // load status
);
    import sfcc_pkg::*;

    localparam int unsigned BW = $clog2(CFG_BYTES + 2); // byte counter width
    localparam int unsigned CW = $clog2(CLEAR_CYCLES + 1); // clear counter width

    // =====================================================
    // system domain: input synchronisers
    logic rq_s1_ff, rq_s2_ff; // reconfig request sync
    logic ini_s1_ff, ini_s2_ff; // init line sync
    logic pu_s1_ff, pu_s2_ff; // pull-up strap sync
    logic [2:0] md_s1_ff, md_s2_ff; // mode strap sync
    logic [1:0] rt_s1_ff, rt_s2_ff; // rate option sync
    logic hr_s1_ff, hr_s2_ff, hr_s3_ff; // link request toggle sync
    logic lk_req_ff; // request toggle from the link
    logic [7:0] hold_ff; // byte held by the link, steady until acked

    // every pin but cfg_ready and the arst_n reset crosses two flops before anything reads it
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {rq_s1_ff, rq_s2_ff, ini_s1_ff, ini_s2_ff} <= 4'h0;
            {pu_s1_ff, pu_s2_ff, md_s1_ff, md_s2_ff} <= 8'h00;
            {rt_s1_ff, rt_s2_ff, hr_s1_ff, hr_s2_ff, hr_s3_ff} <= 7'h00;
        end else begin
            {rq_s2_ff, rq_s1_ff} <= {rq_s1_ff, reconfig_request_n};
            {ini_s2_ff, ini_s1_ff} <= {ini_s1_ff, init_in};
            {pu_s2_ff, pu_s1_ff} <= {pu_s1_ff, pullup_disable};
            {md_s2_ff, md_s1_ff} <= {md_s1_ff, mode_pins};
            {rt_s2_ff, rt_s1_ff} <= {rt_s1_ff, clock_rate_option};
            {hr_s3_ff, hr_s2_ff, hr_s1_ff} <= {hr_s2_ff, hr_s1_ff, lk_req_ff};
        end
    end

    // =====================================================
    // system domain: control sequence
    sfcc_ctl_t ctl_ff, nxt_ctl; // control state
    logic [3:0] low_ff; // reconfig low length
    logic [CW-1:0] clr_ff; // clearing progress
    logic [BW-1:0] bytes_ff; // bytes consumed
    logic [7:0] crc_ff; // running check value
    logic [2:0] mode_ff; // straps caught at init release
    logic [1:0] rate_ff; // rate held for the link
    logic pend_ff; // link byte waiting
    logic ack_ff; // acknowledge toggle to link
    logic prog_hit; // reconfig pulse long enough
    logic consume; // byte taken this cycle
    logic is_crc; // byte is the check byte
    logic f_in_ready, f_out_valid; // fifo handshakes
    logic [7:0] f_out_data; // fifo head
    logic out_valid_ff; // output stage full
    logic [7:0] out_data_ff; // output stage data

    // a short glitch on reconfig is ignored; 8 cycles (320 ns) low counts
    assign prog_hit = (low_ff == 4'(RECONFIG_MIN_CYC));
    assign is_crc = (bytes_ff == BW'(CFG_BYTES));
    // data bytes wait for fifo room, which stalls the link
    assign consume = pend_ff && (ctl_ff != SFCC_C_LOAD || is_crc || f_in_ready);

    // low pulse length, saturating
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_ff <= 4'h0;
        end else if (rq_s2_ff) begin
            low_ff <= 4'h0;
        end else if (!prog_hit) begin
            low_ff <= low_ff + 4'h1;
        end
    end

    // next control state
    always_comb begin
        nxt_ctl = ctl_ff;
        case (ctl_ff)
            SFCC_C_HOLD: begin
                if (rq_s2_ff) begin
                    nxt_ctl = SFCC_C_CLEAR;
                end
            end
            SFCC_C_CLEAR: begin
                if (clr_ff == CW'(CLEAR_CYCLES - 1)) begin
                    nxt_ctl = SFCC_C_WAIT;
                end
            end
            SFCC_C_WAIT: begin
                // external hold on init or reconfig keeps us here
                if (ini_s2_ff && rq_s2_ff) begin
                    nxt_ctl = (md_s2_ff == BOOT_MODE_FLASH) ? SFCC_C_LOAD : SFCC_C_NOBOOT;
                end
            end
            SFCC_C_LOAD: begin
                if (consume && is_crc) begin
                    nxt_ctl = (hold_ff == crc_ff) ? SFCC_C_DONE : SFCC_C_ERROR;
                end
            end
            default: begin
                nxt_ctl = ctl_ff; // done, error, no boot: wait for reconfig
            end
        endcase
        if (prog_hit) begin
            nxt_ctl = SFCC_C_HOLD;
        end
    end

    // state register; power-up starts with clearing
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_ff <= SFCC_C_CLEAR;
        end else begin
            ctl_ff <= nxt_ctl;
        end
    end

    // clearing counter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            clr_ff <= '0;
        end else if (ctl_ff == SFCC_C_CLEAR) begin
            clr_ff <= clr_ff + CW'(1);
        end else begin
            clr_ff <= '0;
        end
    end

    // straps and rate caught as init goes high
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= 3'h0;
            rate_ff <= 2'h0;
        end else if (ctl_ff == SFCC_C_WAIT && nxt_ctl != SFCC_C_WAIT && !prog_hit) begin
            mode_ff <= md_s2_ff;
            rate_ff <= rt_s2_ff;
        end
    end

    // link byte handshake; a new toggle sets pending, set wins
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_ff <= 1'b0;
            ack_ff <= 1'b0;
        end else begin
            if (hr_s2_ff != hr_s3_ff) begin
                pend_ff <= 1'b1;
            end else if (consume) begin
                pend_ff <= 1'b0;
            end
            if (consume) begin
                ack_ff <= ~ack_ff;
            end
        end
    end

    // byte count and crc over the data bytes
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bytes_ff <= '0;
            crc_ff <= CRC_INIT;
        end else if (ctl_ff != SFCC_C_LOAD) begin
            bytes_ff <= '0;
            crc_ff <= CRC_INIT;
        end else if (consume && !is_crc) begin
            bytes_ff <= bytes_ff + BW'(1);
            crc_ff <= sfcc_crc(crc_ff, hold_ff);
        end
    end

    // status pins and levels toward the link
    logic init_oe_ff, done_oe_ff, pu_en_ff; // pin drive registers
    logic start_ff, fin_ff, hiz_ff; // levels to the link
    sfcc_status_t st_ff; // status register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            init_oe_ff <= 1'b1;
            done_oe_ff <= 1'b1;
            pu_en_ff <= 1'b0;
            {start_ff, fin_ff, hiz_ff} <= 3'h0;
            st_ff <= '0;
        end else begin
            init_oe_ff <= (nxt_ctl == SFCC_C_HOLD || nxt_ctl == SFCC_C_CLEAR ||
                           nxt_ctl == SFCC_C_ERROR);
            done_oe_ff <= (nxt_ctl != SFCC_C_DONE);
            pu_en_ff <= !pu_s2_ff && (nxt_ctl != SFCC_C_DONE);
            start_ff <= (nxt_ctl == SFCC_C_LOAD);
            fin_ff <= (nxt_ctl == SFCC_C_DONE);
            hiz_ff <= (nxt_ctl == SFCC_C_HOLD);
            st_ff.busy <= (nxt_ctl == SFCC_C_LOAD);
            st_ff.done <= (nxt_ctl == SFCC_C_DONE);
            st_ff.crc_err <= (nxt_ctl == SFCC_C_ERROR);
            st_ff.no_boot <= (nxt_ctl == SFCC_C_NOBOOT);
        end
    end

    // =====================================================
    // buffering between link and user
    sfcc_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .arst_n(arst_n),
        .in_valid(pend_ff && ctl_ff == SFCC_C_LOAD && !is_crc),
        .in_ready(f_in_ready),
        .in_data(hold_ff),
        .out_valid(f_out_valid),
        .out_ready(!out_valid_ff || cfg_ready),
        .out_data(f_out_data)
    );

    // output stage so the user sees flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= 8'h00;
        end else if (!out_valid_ff || cfg_ready) begin
            out_valid_ff <= f_out_valid;
            out_data_ff <= f_out_data;
        end
    end

    // =====================================================
    // link domain: synchronisers
    logic st_s1_ff, st_s2_ff; // start level
    logic fn_s1_ff, fn_s2_ff; // finished level
    logic hz_s1_ff, hz_s2_ff; // high impedance level
    logic ak_s1_ff, ak_s2_ff; // acknowledge toggle
    logic di_s1_ff, di_s2_ff; // flash data pin
    sfcc_pins_t ap_s1_ff, ap_s2_ff; // application pin values

    always_ff @(posedge osc_clk or negedge arst_n) begin
        if (!arst_n) begin
            {st_s1_ff, st_s2_ff, fn_s1_ff, fn_s2_ff, hz_s1_ff, hz_s2_ff} <= 6'h00;
            {ak_s1_ff, ak_s2_ff, di_s1_ff, di_s2_ff} <= 4'h0;
            ap_s1_ff <= '1;
            ap_s2_ff <= '1;
        end else begin
            {st_s2_ff, st_s1_ff} <= {st_s1_ff, start_ff};
            {fn_s2_ff, fn_s1_ff} <= {fn_s1_ff, fin_ff};
            {hz_s2_ff, hz_s1_ff} <= {hz_s1_ff, hiz_ff};
            {ak_s2_ff, ak_s1_ff} <= {ak_s1_ff, ack_ff};
            {di_s2_ff, di_s1_ff} <= {di_s1_ff, flash_din};
            ap_s2_ff <= ap_s1_ff;
            ap_s1_ff <= app_pins;
        end
    end

    // =====================================================
    // link domain: serial engine
    sfcc_link_t lk_ff; // link state
    logic [3:0] div_ff; // clock divider
    logic [4:0] bit_ff; // bit in command or byte
    logic cmd_ff; // command phase
    logic sclk_ff; // engine serial clock
    logic sel_n_ff; // engine select
    logic [CMD_BITS-1:0] sro_ff; // outgoing command
    logic [7:0] sri_ff; // incoming byte
    logic dout_ff; // chain data
    logic [BW-1:0] nb_ff; // bytes read
    logic tick; // half period elapsed

    // rate_ff is steady before start arrives, so reading it here is safe
    assign tick = (div_ff == sfcc_half(rate_ff) - 4'h1);

    always_ff @(posedge osc_clk or negedge arst_n) begin
        if (!arst_n) begin
            lk_ff <= SFCC_L_IDLE;
            div_ff <= 4'h0;
            bit_ff <= 5'h00;
            cmd_ff <= 1'b0;
            sclk_ff <= 1'b0;
            sel_n_ff <= 1'b1;
            sro_ff <= '0;
            sri_ff <= 8'h00;
            hold_ff <= 8'h00;
            lk_req_ff <= 1'b0;
            dout_ff <= 1'b0;
            nb_ff <= '0;
        end else if (!st_s2_ff) begin
            // abort or not loading: select off, clock parked low
            lk_ff <= SFCC_L_IDLE;
            sel_n_ff <= 1'b1;
            sclk_ff <= 1'b0;
            div_ff <= 4'h0;
        end else begin
            case (lk_ff)
                SFCC_L_IDLE: begin
                    sro_ff <= {READ_CMD, START_ADDR};
                    sel_n_ff <= 1'b0;
                    cmd_ff <= 1'b1;
                    bit_ff <= 5'h00;
                    nb_ff <= '0;
                    lk_ff <= SFCC_L_SHIFT;
                end
                SFCC_L_SHIFT: begin
                    div_ff <= tick ? 4'h0 : div_ff + 4'h1;
                    if (tick && !sclk_ff) begin
                        sclk_ff <= 1'b1;
                        if (!cmd_ff) begin
                            sri_ff <= {sri_ff[6:0], di_s2_ff};
                            dout_ff <= di_s2_ff;
                        end
                    end else if (tick) begin
                        sclk_ff <= 1'b0;
                        bit_ff <= bit_ff + 5'h01;
                        if (cmd_ff) begin
                            sro_ff <= {sro_ff[CMD_BITS-2:0], 1'b0};
                            if (bit_ff == 5'(CMD_BITS - 1)) begin
                                cmd_ff <= 1'b0;
                                bit_ff <= 5'h00;
                            end
                        end else if (bit_ff == 5'h07) begin
                            bit_ff <= 5'h00;
                            hold_ff <= sri_ff;
                            lk_req_ff <= ~lk_req_ff;
                            nb_ff <= nb_ff + BW'(1);
                            // the check byte is last; select then drops
                            lk_ff <= (nb_ff == BW'(CFG_BYTES)) ? SFCC_L_END : SFCC_L_WAIT;
                        end
                    end
                end
                SFCC_L_WAIT: begin
                    // clock stays low until the system side took the byte
                    if (ak_s2_ff == lk_req_ff) begin
                        lk_ff <= SFCC_L_SHIFT;
                    end
                end
                default: begin
                    sel_n_ff <= 1'b1;
                end
            endcase
        end
    end

    // pin drivers: hand-off, high impedance, or engine
    sfcc_pins_t pin_ff; // pin values
    logic pin_oe_ff; // pins driven
    always_ff @(posedge osc_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_ff <= '1;
            pin_oe_ff <= 1'b0;
        end else if (hz_s2_ff) begin
            pin_ff <= '1;
            pin_oe_ff <= 1'b0;
        end else if (fn_s2_ff) begin
            pin_ff <= ap_s2_ff;
            pin_oe_ff <= 1'b1;
        end else begin
            pin_ff <= '{sel_n: sel_n_ff, sclk: sclk_ff, mosi: sro_ff[CMD_BITS-1],
                        dout: dout_ff};
            pin_oe_ff <= 1'b1;
        end
    end

    // =====================================================
    // outputs
    assign init_out = 1'b0;
    assign done_out = 1'b0;
    assign init_oe = init_oe_ff;
    assign done_oe = done_oe_ff;
    assign pullup_en = pu_en_ff;
    assign flash_select_n = pin_ff.sel_n;
    assign cfg_serial_clock = pin_ff.sclk;
    assign mosi = pin_ff.mosi;
    assign chain_dout = pin_ff.dout;
    assign flash_select_oe = pin_oe_ff;
    assign sclk_oe = pin_oe_ff;
    assign mosi_oe = pin_oe_ff;
    assign chain_dout_oe = pin_oe_ff;
    assign cfg_data = out_data_ff;
    assign cfg_valid = out_valid_ff;
    assign status = st_ff;
endmodule

/* hdl/sfcc_pkg.sv */
package sfcc_pkg;

    // =====================================================
    // timing
    localparam int unsigned REF_CLK_MHZ = 25; // system clock rate
    localparam int unsigned REF_PERIOD_NS = 40; // system clock period
    localparam int unsigned RECONFIG_MIN_NS = 300; // least reconfig pulse
    localparam int unsigned RECONFIG_MIN_CYC =
        (RECONFIG_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS; // rounded up
    localparam int unsigned CLEAR_TIME_US = 1000; // memory clearing time
    localparam int unsigned CLEAR_CYC = CLEAR_TIME_US * REF_CLK_MHZ; // cycles

    // =====================================================
    // flash command and boot straps
    localparam logic [7:0] READ_CMD = 8'h03; // memory read opcode
    localparam logic [23:0] START_ADDR = 24'h000000; // stream starts at zero
    localparam int unsigned CMD_BITS = 32; // opcode plus address
    localparam logic [2:0] BOOT_MODE_FLASH = 3'h1; // straps 0,0,1
    localparam logic [7:0] CRC_POLY = 8'h07; // crc-8 polynomial
    localparam logic [7:0] CRC_INIT = 8'h00; // crc seed

    // =====================================================
    // states
    typedef enum logic [2:0] {
        SFCC_C_HOLD = 3'h0,
        SFCC_C_CLEAR = 3'h1,
        SFCC_C_WAIT = 3'h2,
        SFCC_C_LOAD = 3'h3,
        SFCC_C_DONE = 3'h4,
        SFCC_C_ERROR = 3'h5,
        SFCC_C_NOBOOT = 3'h6
    } sfcc_ctl_t;

    typedef enum logic [1:0] {
        SFCC_L_IDLE = 2'h0,
        SFCC_L_SHIFT = 2'h1,
        SFCC_L_WAIT = 2'h2,
        SFCC_L_END = 2'h3
    } sfcc_link_t;

    // =====================================================
    // carriers
    typedef struct packed {
        logic sel_n; // flash select, active low
        logic sclk; // serial clock
        logic mosi; // data to flash
        logic dout; // chain output
    } sfcc_pins_t;

    typedef struct packed {
        logic busy; // loading in progress
        logic done; // load finished well
        logic crc_err; // stream failed its check
        logic no_boot; // straps not serial flash
    } sfcc_status_t;

    // half period of the serial clock in oscillator cycles
    function automatic logic [3:0] sfcc_half(input logic [1:0] rate);
        case (rate)
            2'h0: sfcc_half = 4'hc;
            2'h1: sfcc_half = 4'h8;
            2'h2: sfcc_half = 4'h6;
            default: sfcc_half = 4'h4;
        endcase
    endfunction

    // one byte through the crc, msb first
    function automatic logic [7:0] sfcc_crc(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        sfcc_crc = c;
    endfunction

endpackage

/* verification/sfcc_config_ctrl_assertions.sv */
`timescale 1ns/100ps
// =====================================================
// port checker
module sfcc_config_ctrl_assertions
    import sfcc_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic osc_clk, // link clock
    input wire logic arst_n, // reset, low
    input wire logic reconfig_request_n, // reprogram
    input wire logic init_in, // init level
    input wire logic init_oe, // init pulled
    input wire logic done_oe, // done pulled
    input wire logic flash_select_n, // select
    input wire logic flash_select_oe, // pins driven
    input wire logic cfg_serial_clock, // serial clock
    input wire sfcc_status_t status // load status
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_low; !reconfig_request_n [*8]; endsequence
    sequence s_off; init_oe && done_oe && !flash_select_oe; endsequence
    property p_clr; $rose(arst_n) |-> init_oe [*8]; endproperty
    a_clr: assert property (p_clr) else $error("init freed early");
    property p_rel; $rose(arst_n) |-> ##[18:40] !init_oe; endproperty
    a_rel: assert property (p_rel) else $error("init kept low");
    property p_go; $rose(status.busy) |-> init_in && reconfig_request_n; endproperty
    a_go: assert property (p_go) else $error("load while held");
    property p_ld; status.busy |-> done_oe; endproperty
    a_ld: assert property (p_ld) else $error("done freed in load");
    property p_dn; $fell(done_oe) |-> ##[0:2] status.done; endproperty
    a_dn: assert property (p_dn) else $error("done freed early");
    property p_crc; status.crc_err |-> init_oe; endproperty
    a_crc: assert property (p_crc) else $error("crc fault not flagged");
    property p_hld; s_low |-> ##[0:12] s_off; endproperty
    a_hld: assert property (p_hld) else $error("hold not taken");
    // clock may only rise while selected
    property p_clk; @(posedge osc_clk) disable iff (!arst_n)
        $rose(cfg_serial_clock) && flash_select_oe && !status.done |-> !flash_select_n;
    endproperty
    a_clk: assert property (p_clk) else $error("clock unselected");
    property p_cs; @(posedge osc_clk) disable iff (!arst_n)
        $fell(flash_select_n) && flash_select_oe && !status.done |-> status.busy;
    endproperty
    a_cs: assert property (p_cs) else $error("select outside load");
endmodule
bind sfcc_config_ctrl sfcc_config_ctrl_assertions u_sfcc_config_ctrl_assertions (.*);

/* verification/sfcc_config_ctrl_tb.sv */
`timescale 1ns/100ps
// =====================================================
// bench
module sfcc_config_ctrl_tb;
    import sfcc_pkg::*;
    localparam int N = 4; // stream bytes
    logic ref_clk = 0, osc_clk = 0, arst_n = 0, reconfig_request_n = 1, bad = 0;
    logic pullup_disable = 0, ext_hold = 0, cfg_ready = 0, init_in, init_out, init_oe;
    logic done_out, done_oe, pullup_en, flash_select_n, flash_select_oe, cfg_serial_clock;
    logic sclk_oe, mosi, mosi_oe, flash_din, chain_dout, chain_dout_oe, cfg_valid;
    logic [2:0] mode_pins = 3'h1; // boot straps
    logic [1:0] clock_rate_option = 2'h0; // serial rate
    logic [7:0] cfg_data, seed = 8'h00, q[$]; // bytes taken
    logic [31:0] cmd; // command seen
    sfcc_pins_t app_pins = 4'h8; // select parked high
    sfcc_status_t status; // load status
    int error_cnt = 0, checks_done = 0;
    always #20 ref_clk = ~ref_clk;
    always #24 osc_clk = ~osc_clk;
    // open-drain with pull-up
    assign init_in = !(init_oe | ext_hold);
    sfcc_config_ctrl #(.CLEAR_CYCLES(20), .CFG_BYTES(N)) u_sfcc_config_ctrl (.*);
    sfcc_flash_model #(.N(N)) u_sfcc_flash_model (.sel_n(!flash_select_oe | flash_select_n),
        .sclk(cfg_serial_clock & sclk_oe), .bad, .seed, .mosi_in(mosi), .cmd, .dq(flash_din));
    // reader stalls at random
    always @(negedge ref_clk) cfg_ready <= 1'($urandom);
    always @(posedge ref_clk) if (cfg_valid && cfg_ready) q.push_back(cfg_data);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one load: straps, crc fault, init held, rate
    task automatic run(input logic [2:0] m, input logic b, input logic h, input logic [1:0] r);
        int i;
        logic ok;
        ok = m == 3'h1 && !b;
        {seed, pullup_disable} = 9'($urandom);
        {mode_pins, bad, ext_hold, app_pins, clock_rate_option} = {m, b, h, 4'h8, r};
        reconfig_request_n = 0;
        repeat (10) @(negedge ref_clk);
        reconfig_request_n = 1;
        q.delete();
        repeat (40) @(negedge ref_clk);
        if (h) begin
            chk(status, 4'h0);
            chk(pullup_en, !pullup_disable);
            ext_hold = 0;
        end
        for (i = 0; i < 9000 && !(status.done | status.crc_err | status.no_boot); i++)
            @(negedge ref_clk);
        if (i == 9000) begin
            chk(0, 1);
            close_out();
        end
        repeat (12) @(negedge ref_clk);
        chk(status, {1'b0, ok, b && m == 3'h1, m != 3'h1});
        chk(init_oe, b && m == 3'h1);
        chk(done_oe, !ok);
        if (ok) begin
            for (i = 0; i < N; i++) chk(q[i], seed + 8'(i));
            chk(cmd, {READ_CMD, START_ADDR});
            app_pins = 4'($urandom);
            repeat (8) @(negedge ref_clk);
            chk(flash_select_n, app_pins.sel_n);
        end
        $display("test done mode %h fault %0d", m, b);
    endtask
    initial begin
        void'($urandom(74222));
        repeat (20) @(negedge ref_clk);
        arst_n = 1;
        run(3'h1, 1, 1, 2'h3);
        run(3'h2, 0, 0, 2'h1);
        for (int t = 0; t < 4; t++) run(3'h1, 0, 0, 2'(t));
        // glitch too short to restart
        reconfig_request_n = 0;
        repeat (4) @(negedge ref_clk);
        reconfig_request_n = 1;
        repeat (40) @(negedge ref_clk);
        chk(done_oe, 0);
        close_out();
    end
endmodule

/* verification/sfcc_flash_model.sv */
`timescale 1ns/100ps
// =====================================================
// flash holding the stream
module sfcc_flash_model #(
    parameter int N = 4 // data bytes
) (
    input wire logic sel_n, // select, low
    input wire logic sclk, // serial clock
    input wire logic bad, // spoil check byte
    input wire logic [7:0] seed, // first byte
    input wire logic mosi_in, // command in
    output logic [31:0] cmd, // command seen
    output logic dq = 0 // data out
);
    int cnt = 0; // rising edges in frame
    logic [7:0] w; // byte on the wire
    // stream byte i, check byte last
    function automatic logic [7:0] sb(int i);
        logic [7:0] c = 0;
        if (i < N) return seed + 8'(i);
        for (int k = 0; k < N; k++) begin
            c ^= seed + 8'(k);
            repeat (8) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
        end
        return c ^ {7'h0, bad};
    endfunction
    // command taken on rising edge
    always @(posedge sclk or posedge sel_n) begin
        if (sel_n) begin
            cnt <= 0;
        end else begin
            if (cnt < 32) cmd <= {cmd[30:0], mosi_in};
            cnt <= cnt + 1;
        end
    end
    // released line inverts so no stale bit
    always @(negedge sclk or posedge sel_n) begin
        w = sb((cnt - 32) / 8);
        if (sel_n) dq <= ~dq;
        else if (cnt >= 32) dq <= w[7 - (cnt - 32) % 8];
    end
endmodule
